//--- reset_cause_and_power_on_clear.sv
// Summary of operation
// - Cause register sits at byte address FFFA8H, read only.
// - Software reads the cause register as one whole byte.
// - Reset pin, power-on clear, or a byte read clear all four flags.
// - Opcode FFH raises internal reset and sets bit 7, others kept.
// - Watchdog reset sets bit 4, other flags kept.
// - Reset-processing check error sets bit 1, other flags kept.
// - Low-voltage detector reset sets bit 0, other flags kept.
// - Watchdog, low-voltage and opcode resets never clear the register.
// - Opcode FFH under debug control raises no reset.
// - With default low-voltage start, bit 0 may read 1 after power-up.
// - Hold internal reset until rise detector reports supply above 1.61 V.
// - With default low-voltage start, hold reset until supply exceeds 2.07 V.
// - Fall detector below 1.59 V asserts internal reset at once.
// - With default low-voltage start, a rise under 5.8 ms releases 2.12 to 5.84 ms after threshold.
// - With default low-voltage start, a slow rise waits 195 to 341 us after reaching 2.07 V.
// - Processing interval covers oscillator accuracy settling before the CPU runs.
`timescale 1ns/10ps
module reset_cause_and_power_on_clear
	import rcause_pkg::*;
#(
	parameter int TICK_CYCLES      = TICK_CYCLES_DEF,
	parameter int RISE_LIMIT_TICKS = rcause_pkg::RISE_LIMIT_TICKS,
	parameter int POC_MIN_TICKS    = rcause_pkg::POC_MIN_TICKS,
	parameter int POC_MAX_TICKS    = rcause_pkg::POC_MAX_TICKS,
	parameter int PROC_MIN_TICKS   = rcause_pkg::PROC_MIN_TICKS,
	parameter int PROC_MAX_TICKS   = rcause_pkg::PROC_MAX_TICKS
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        supply_rise_ok,
	input  wire logic        supply_fall_low,
	input  wire logic        lvd_level_ok,
	input  wire logic        ext_reset_n,
	input  wire logic        lvd_default_disable_option,
	input  wire logic        watchdog_reset_req,
	input  wire logic        init_check_err,
	input  wire logic        lvd_reset_req,
	input  wire logic        opcode_exec,
	input  wire logic [7:0]  opcode,
	input  wire logic        debug_active,
	input  wire logic [19:0] bus_addr,
	input  wire logic        bus_rd,
	input  wire logic        bus_byte_access,
	output logic      [7:0]  bus_rdata,
	output logic             bus_rvalid,
	output logic             internal_reset_n,
	output logic             cpu_run,
	output logic             lvd_default_enabled
);
	localparam logic [TIMER_W-1:0] RISE_T     = TIMER_W'(RISE_LIMIT_TICKS);
	localparam logic [TIMER_W-1:0] POC_MIN_T  = TIMER_W'(POC_MIN_TICKS);
	localparam logic [TIMER_W-1:0] POC_MAX_T  = TIMER_W'(POC_MAX_TICKS);
	localparam logic [TIMER_W-1:0] PROC_MIN_T = TIMER_W'(PROC_MIN_TICKS);
	localparam logic [TIMER_W-1:0] PROC_MAX_T = TIMER_W'(PROC_MAX_TICKS);

	typedef struct packed {
		seq_state_t   st;
		cause_flags_t flags;
		logic         opt_off;
		logic         poc_target;
		logic [7:0]   rdata;
		logic         rvalid;
	} ctl_t;

	localparam ctl_t CTL_RESET = '{
		st:         ST_HOLD,
		flags:      CAUSE_CLEAR,
		opt_off:    1'b0,
		poc_target: 1'b1,
		rdata:      CAUSE_READ_ZERO,
		rvalid:     1'b0
	};

	function automatic logic [7:0] cause_image(input cause_flags_t f);
		logic [7:0] v;
		v           = CAUSE_READ_ZERO;
		v[TRAP_BIT] = f.trap;
		v[WD_BIT]   = f.watchdog;
		v[INIT_BIT] = f.init_check;
		v[LV_BIT]   = f.low_voltage;
		return v;
	endfunction

	ctl_t                r;
	ctl_t                r_nxt;
	pin_in_t             pins_raw;
	pin_in_t             pins;
	logic [TIMER_W-1:0]  elapsed;
	logic                tmr_restart;
	logic                poc_hold;
	logic                ext_hold;
	logic                live;
	logic                illegal_op;
	logic                lvd_dip;
	logic                rd_match;
	logic                rd_clear;
	logic                any_set;
	logic [TIMER_W-1:0]  proc_target;
	cause_flags_t        set_req;

	// Detector outputs and the reset pin are asynchronous to clk
	assign pins_raw = '{
		supply_rise_ok:             supply_rise_ok,
		supply_fall_low:            supply_fall_low,
		lvd_level_ok:               lvd_level_ok,
		ext_reset_n:                ext_reset_n,
		lvd_default_disable_option: lvd_default_disable_option
	};

	bit_sync #(
		.W($bits(pin_in_t))
	) u_pin_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      (pins_raw),
		.q      (pins)
	);

	interval_timer #(
		.TICK_CYCLES (TICK_CYCLES),
		.W           (TIMER_W)
	) u_timer (
		.clk     (clk),
		.arst_n  (arst_n),
		.restart (tmr_restart),
		.elapsed (elapsed)
	);

	assign poc_hold   = pins.supply_fall_low | ~pins.supply_rise_ok;
	assign ext_hold   = ~pins.ext_reset_n;
	assign live       = (r.st != ST_HOLD) && (r.st != ST_EXT) && !poc_hold && !ext_hold;
	assign illegal_op = opcode_exec && (opcode == ILLEGAL_OPCODE) && !debug_active;
	assign lvd_dip    = !r.opt_off && !pins.lvd_level_ok &&
	                    ((r.st == ST_PROC) || (r.st == ST_RUN));
	assign rd_match   = bus_rd && (bus_addr == CAUSE_REG_ADDR);
	assign rd_clear   = rd_match && bus_byte_access;

	// Each source drives its own bit only
	assign set_req.trap        = live & illegal_op;
	assign set_req.watchdog    = live & watchdog_reset_req;
	assign set_req.init_check  = live & init_check_err;
	assign set_req.low_voltage = live & (lvd_reset_req | lvd_dip);
	assign any_set             = |set_req;
	assign proc_target         = r.poc_target ? POC_MIN_T : PROC_MIN_T;

	always_comb begin
		r_nxt        = r;
		r_nxt.rvalid = 1'b0;
		tmr_restart  = 1'b0;
		if (rd_match) begin
			r_nxt.rdata  = cause_image(r.flags);
			r_nxt.rvalid = 1'b1;
		end
		if (rd_clear) begin
			r_nxt.flags = CAUSE_CLEAR;
		end
		// A source firing in the cycle of a read survives the read clear
		r_nxt.flags = r_nxt.flags | set_req;
		if (poc_hold || ext_hold) begin
			r_nxt.flags = CAUSE_CLEAR;
		end
		if (poc_hold) begin
			r_nxt.st         = ST_HOLD;
			r_nxt.poc_target = 1'b1;
			tmr_restart      = 1'b1;
		end else if (ext_hold) begin
			r_nxt.st    = ST_EXT;
			tmr_restart = 1'b1;
		end else begin
			unique case (r.st)
				ST_HOLD: begin
					// Strap taken once the supply is up, never inside the reset branch
					r_nxt.opt_off    = pins.lvd_default_disable_option;
					r_nxt.poc_target = 1'b0;
					tmr_restart      = 1'b1;
					if (pins.lvd_default_disable_option) begin
						r_nxt.st = ST_PROC;
					end else begin
						r_nxt.st         = ST_WAIT_LVD;
						r_nxt.poc_target = 1'b1;
					end
				end
				ST_WAIT_LVD: begin
					if (pins.lvd_level_ok) begin
						r_nxt.st = ST_PROC;
						if (r.poc_target && (elapsed < RISE_T)) begin
							r_nxt.poc_target = 1'b1;
						end else begin
							r_nxt.poc_target = 1'b0;
							tmr_restart      = 1'b1;
						end
					end
				end
				ST_PROC: begin
					if (lvd_dip) begin
						r_nxt.st         = ST_WAIT_LVD;
						r_nxt.poc_target = 1'b0;
					end else if (any_set) begin
						r_nxt.poc_target = 1'b0;
						tmr_restart      = 1'b1;
					end else if (elapsed >= proc_target) begin
						r_nxt.st = ST_RUN;
					end
				end
				ST_RUN: begin
					if (lvd_dip) begin
						r_nxt.st         = ST_WAIT_LVD;
						r_nxt.poc_target = 1'b0;
					end else if (any_set) begin
						r_nxt.st         = ST_PROC;
						r_nxt.poc_target = 1'b0;
						tmr_restart      = 1'b1;
					end
				end
				ST_EXT: begin
					r_nxt.st         = ST_PROC;
					r_nxt.poc_target = 1'b0;
					tmr_restart      = 1'b1;
				end
				default: begin
					r_nxt.st    = ST_HOLD;
					tmr_restart = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= CTL_RESET;
		end else begin
			r <= r_nxt;
		end
	end

	assign bus_rdata           = r.rdata;
	assign bus_rvalid          = r.rvalid;
	assign cpu_run             = (r.st == ST_RUN);
	assign internal_reset_n    = (r.st == ST_RUN);
	assign lvd_default_enabled = ~r.opt_off;

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (!arst_n);

	sequence s_quiet;
		!any_set && !poc_hold && !ext_hold;
	endsequence

	sequence s_byte_read;
		rd_clear;
	endsequence

	sequence s_release;
		$rose(cpu_run);
	endsequence

	property p_flag_kept_set(logic src, logic flag);
		(src && live && !rd_clear) |=> flag && ((cause_flags_t'($past(r.flags)) & ~r.flags) == '0);
	endproperty

	chk_addr_decode: assert property (
		(bus_rd && (bus_addr != CAUSE_REG_ADDR)) |=> !bus_rvalid
	) else $error("answer to a foreign address");

	chk_read_clear: assert property (
		(s_byte_read and s_quiet) |=> (r.flags == CAUSE_CLEAR)
	) else $error("byte read did not clear flags");

	chk_read_value: assert property (
		rd_match |=> bus_rvalid && (bus_rdata == cause_image($past(r.flags)))
	) else $error("read data not the pre-clear flags");

	chk_trap_set: assert property (
		p_flag_kept_set(illegal_op, r.flags.trap)
	) else $error("illegal opcode flag not set");

	chk_wd_set: assert property (
		p_flag_kept_set(watchdog_reset_req, r.flags.watchdog)
	) else $error("watchdog flag not set or other flag lost");

	chk_init_set: assert property (
		p_flag_kept_set(init_check_err, r.flags.init_check)
	) else $error("init check flag not set");

	chk_lv_set: assert property (
		p_flag_kept_set(lvd_reset_req, r.flags.low_voltage)
	) else $error("low voltage flag not set");

	chk_set_over_read: assert property (
		(rd_clear && watchdog_reset_req && live) |=> r.flags.watchdog
	) else $error("read clear swallowed a new watchdog event");

	chk_debug_no_reset: assert property (
		(cpu_run && opcode_exec && (opcode == ILLEGAL_OPCODE) && debug_active) ##0 s_quiet
		|=> cpu_run
	) else $error("debug opcode raised a reset");

	chk_lv_dip_flag: assert property (
		(lvd_dip && !poc_hold && !ext_hold) |=> r.flags.low_voltage && (r.st == ST_WAIT_LVD)
	) else $error("default low voltage dip not recorded");

	chk_rise_hold: assert property (
		((r.st == ST_HOLD) && poc_hold) |=> (r.st == ST_HOLD) && !internal_reset_n
	) else $error("released before supply rise");

	chk_lvd_wait: assert property (
		((r.st == ST_WAIT_LVD) && !pins.lvd_level_ok && !poc_hold && !ext_hold)
		|=> (r.st == ST_WAIT_LVD) && !internal_reset_n
	) else $error("released below low voltage level");

	chk_fall_reset: assert property (
		poc_hold |=> !internal_reset_n && (r.flags == CAUSE_CLEAR)
	) else $error("supply fall did not reset");

	chk_fast_window: assert property (
		(s_release ##0 $past(r.poc_target))
		|-> ($past(elapsed) >= POC_MIN_T) && ($past(elapsed) <= POC_MAX_T)
	) else $error("fast rise release outside window");

	chk_slow_window: assert property (
		(s_release ##0 !$past(r.poc_target))
		|-> ($past(elapsed) >= PROC_MIN_T) && ($past(elapsed) <= PROC_MAX_T)
	) else $error("processing time outside window");

	chk_joint_set: assert property (
		(watchdog_reset_req && init_check_err && illegal_op && live)
		|=> r.flags.watchdog && r.flags.init_check && r.flags.trap
	) else $error("simultaneous sources not all recorded");

	chk_bit_read_keep: assert property (
		(rd_match && !bus_byte_access) ##0 s_quiet |=> (r.flags == $past(r.flags))
	) else $error("bit read changed the flags");

	chk_pin_clear: assert property (
		(ext_hold && !poc_hold)
		|=> !internal_reset_n && (r.flags == CAUSE_CLEAR) && (r.st == ST_EXT)
	) else $error("reset pin did not clear flags");
endmodule

//--- rcause_pkg.sv
package rcause_pkg;
	localparam logic [19:0] CAUSE_REG_ADDR  = 20'hFFFA8;
	localparam int          TRAP_BIT        = 7;
	localparam int          WD_BIT          = 4;
	localparam int          INIT_BIT        = 1;
	localparam int          LV_BIT          = 0;
	localparam logic [7:0]  ILLEGAL_OPCODE  = 8'hFF;
	localparam logic [7:0]  CAUSE_READ_ZERO = 8'h00;

	localparam int CLK_MHZ         = 100;
	localparam int TICK_US         = 1;
	localparam int TICK_CYCLES_DEF = CLK_MHZ * TICK_US;

	localparam int RISE_LIMIT_US = 5800;
	localparam int POC_MIN_US    = 2120;
	localparam int POC_MAX_US    = 5840;
	localparam int PROC_MIN_US   = 195;
	localparam int PROC_MAX_US   = 341;

	localparam int RISE_LIMIT_TICKS = RISE_LIMIT_US / TICK_US;
	localparam int POC_MIN_TICKS    = (POC_MIN_US + TICK_US - 1) / TICK_US;
	localparam int POC_MAX_TICKS    = POC_MAX_US / TICK_US;
	localparam int PROC_MIN_TICKS   = (PROC_MIN_US + TICK_US - 1) / TICK_US;
	localparam int PROC_MAX_TICKS   = PROC_MAX_US / TICK_US;
	localparam int TIMER_W          = 13;

	typedef struct packed {
		logic trap;
		logic watchdog;
		logic init_check;
		logic low_voltage;
	} cause_flags_t;

	localparam cause_flags_t CAUSE_CLEAR = '0;

	typedef struct packed {
		logic supply_rise_ok;
		logic supply_fall_low;
		logic lvd_level_ok;
		logic ext_reset_n;
		logic lvd_default_disable_option;
	} pin_in_t;

	localparam pin_in_t PIN_RESET = '0;

	typedef enum logic [2:0] {
		ST_HOLD     = 3'h0,
		ST_WAIT_LVD = 3'h1,
		ST_PROC     = 3'h3,
		ST_RUN      = 3'h2,
		ST_EXT      = 3'h6
	} seq_state_t;
endpackage

//--- bit_sync.sv
`timescale 1ns/10ps
module bit_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_t;

	sync_t r;
	sync_t r_nxt;

	always_comb begin
		r_nxt    = r;
		r_nxt.s1 = d;
		r_nxt.s2 = r.s1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign q = r.s2;
endmodule

//--- interval_timer.sv
`timescale 1ns/10ps
module interval_timer #(
	parameter int TICK_CYCLES = 100,
	parameter int W           = 13
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         restart,
	output logic      [W-1:0] elapsed
);
	localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam logic [TW-1:0] DIV_LAST = TW'(TICK_CYCLES - 1);

	typedef struct packed {
		logic [TW-1:0] div;
		logic [W-1:0]  cnt;
	} tmr_t;

	tmr_t r;
	tmr_t r_nxt;

	// Saturates so long waits never wrap into a short one
	always_comb begin
		r_nxt = r;
		if (restart) begin
			r_nxt.div = '0;
			r_nxt.cnt = '0;
		end else if (r.div == DIV_LAST) begin
			r_nxt.div = '0;
			if (r.cnt != '1) begin
				r_nxt.cnt = r.cnt + W'(1);
			end
		end else begin
			r_nxt.div = r.div + TW'(1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	assign elapsed = r.cnt;
endmodule

//--- supply_detector_model.sv
`timescale 1ns/10ps
module supply_detector_model #(
	parameter int RISE_MV = 1610,
	parameter int FALL_MV = 1590,
	parameter int LVD_MV  = 2070
) (
	input  wire logic [12:0] supply_mv,
	input  wire logic        ext_hold,
	output logic             supply_rise_ok,
	output logic             supply_fall_low,
	output logic             lvd_level_ok,
	output logic             ext_reset_n
);
	// Ideal comparators; the design synchronises them, so no hysteresis here
	assign supply_rise_ok  = (supply_mv > 13'(RISE_MV));
	assign supply_fall_low = (supply_mv < 13'(FALL_MV));
	assign lvd_level_ok    = (supply_mv > 13'(LVD_MV));
	// Board holds the pin low while ext_hold is set
	assign ext_reset_n     = ~ext_hold;
endmodule

//--- testbench.sv
`timescale 1ns/10ps
module testbench;
	import rcause_pkg::*;
	localparam int TC   = 2;
	localparam int PMIN = 8;
	localparam int PMAX = 22;
	localparam int QMIN = 3;
	localparam int QMAX = 6;
	localparam int SLK  = 6;
	typedef struct packed {
		logic [3:0] src;
		logic [7:0] opc;
		logic       dbg;
		logic       rst;
		logic [7:0] flags;
	} row_t;
	logic        clk, arst_n, ext_hold, strap, wd, ini, lvr, opx, dbg, rd, byte_acc;
	logic        rvalid, irst_n, run, lvd_en, rise_ok, fall_low, lvd_ok, ext_n;
	logic [12:0] mv;
	logic [7:0]  opc, rdata;
	logic [19:0] addr;
	int          errors, samples_checked, n;
	row_t        rows [7];

	supply_detector_model u_sup (.supply_mv(mv), .ext_hold(ext_hold), .supply_rise_ok(rise_ok),
		.supply_fall_low(fall_low), .lvd_level_ok(lvd_ok), .ext_reset_n(ext_n));

	reset_cause_and_power_on_clear #(.TICK_CYCLES(TC), .RISE_LIMIT_TICKS(20),
		.POC_MIN_TICKS(PMIN), .POC_MAX_TICKS(PMAX), .PROC_MIN_TICKS(QMIN),
		.PROC_MAX_TICKS(QMAX)) u_dut (.clk(clk), .arst_n(arst_n), .supply_rise_ok(rise_ok),
		.supply_fall_low(fall_low), .lvd_level_ok(lvd_ok), .ext_reset_n(ext_n),
		.lvd_default_disable_option(strap), .watchdog_reset_req(wd), .init_check_err(ini),
		.lvd_reset_req(lvr), .opcode_exec(opx), .opcode(opc), .debug_active(dbg),
		.bus_addr(addr), .bus_rd(rd), .bus_byte_access(byte_acc), .bus_rdata(rdata),
		.bus_rvalid(rvalid), .internal_reset_n(irst_n), .cpu_run(run),
		.lvd_default_enabled(lvd_en));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic conclude;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp1(input logic got, input logic exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %b", $time, m, got);
		end
	endtask

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// Read strobe is one cycle; data is sampled just after the taking edge
	task automatic read_chk(input logic [19:0] a, input logic b, input logic ev,
		input logic [7:0] ed);
		@(posedge clk);
		addr <= a;
		byte_acc <= b;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		cmp1(rvalid, ev, "read valid");
		if (ev) begin
			cmp8(rdata, ed, "read data");
		end
	endtask

	task automatic wait_run;
		n = 0;
		while (run !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmp1(run, 1'b1, "cpu never released");
	endtask

	task automatic pulse(input row_t r);
		@(posedge clk);
		wd <= r.src[3];
		ini <= r.src[2];
		lvr <= r.src[1];
		opx <= r.src[0];
		opc <= r.opc;
		dbg <= r.dbg;
		@(posedge clk);
		{wd, ini, lvr, opx, dbg} <= '0;
		@(posedge clk);
		#1;
	endtask

	initial begin
		#200000;
		errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		conclude();
	end

	initial begin
		{arst_n, ext_hold, strap, wd, ini, lvr, opx, dbg, rd, byte_acc} = '0;
		mv = 13'h0000;
		opc = 8'h00;
		addr = CAUSE_REG_ADDR;
		errors = 0;
		samples_checked = 0;
		// Ordinary events: sources, opcode, debug, all at once
		rows = '{'{4'h8, 8'h00, 1'b0, 1'b1, 8'h10}, '{4'h4, 8'h00, 1'b0, 1'b1, 8'h02},
			'{4'h2, 8'h00, 1'b0, 1'b1, 8'h01}, '{4'h1, 8'hFF, 1'b0, 1'b1, 8'h80},
			'{4'h1, 8'hFF, 1'b1, 1'b0, 8'h00}, '{4'h1, 8'h3C, 1'b0, 1'b0, 8'h00},
			'{4'hF, 8'hFF, 1'b0, 1'b1, 8'h93}};
		repeat (4) @(posedge clk);
		cmp1(irst_n, 1'b0, "reset during power-up");
		cmp1(lvd_en, 1'b1, "default low-voltage start");
		arst_n <= 1'b1;
		repeat (6) @(posedge clk);
		cmp1(run, 1'b0, "run before supply");
		mv <= 13'h09C4;
		wait_run();
		cmp1(n >= PMIN * TC && n <= PMAX * TC + SLK, 1'b1, "fast power-up window");
		repeat (50) @(posedge clk);
		read_chk(CAUSE_REG_ADDR, 1'b1, 1'b1, 8'h00);
		$display("test power_up done");
		for (int i = 0; i < 7; i++) begin
			pulse(rows[i]);
			cmp1(run, ~rows[i].rst, "run after event");
			wait_run();
			read_chk(CAUSE_REG_ADDR, 1'b1, 1'b1, rows[i].flags);
			read_chk(CAUSE_REG_ADDR, 1'b1, 1'b1, 8'h00);
		end
		$display("test event_table done");
		pulse(rows[0]);
		wait_run();
		pulse(rows[3]);
		wait_run();
		read_chk(CAUSE_REG_ADDR, 1'b0, 1'b1, 8'h90);
		read_chk(CAUSE_REG_ADDR, 1'b1, 1'b1, 8'h90);
		read_chk(CAUSE_REG_ADDR, 1'b1, 1'b1, 8'h00);
		read_chk(CAUSE_REG_ADDR + 20'h00001, 1'b1, 1'b0, 8'h00);
		@(posedge clk);
		addr <= CAUSE_REG_ADDR;
		rd <= 1'b1;
		wd <= 1'b1;
		@(posedge clk);
		{rd, wd} <= '0;
		#1;
		cmp1(rvalid, 1'b1, "read beside event valid");
		cmp8(rdata, 8'h00, "read beside event");
		wait_run();
		read_chk(CAUSE_REG_ADDR, 1'b1, 1'b1, 8'h10);
		$display("test held_flags done");
		pulse(rows[3]);
		wait_run();
		ext_hold <= 1'b1;
		repeat (8) @(posedge clk);
		cmp1(irst_n, 1'b0, "reset pin held");
		ext_hold <= 1'b0;
		wait_run();
		cmp1(n >= QMIN * TC && n <= QMAX * TC + SLK, 1'b1, "pin release window");
		read_chk(CAUSE_REG_ADDR, 1'b1, 1'b1, 8'h00);
		$display("test reset_pin done");
		pulse(rows[0]);
		wait_run();
		mv <= 13'h05DC;
		repeat (6) @(posedge clk);
		cmp1(irst_n, 1'b0, "supply fall");
		mv <= 13'h06A4;
		repeat (30 * TC) @(posedge clk);
		cmp1(run, 1'b0, "below detection level");
		mv <= 13'h09C4;
		wait_run();
		cmp1(n >= QMIN * TC && n <= QMAX * TC + SLK, 1'b1, "slow rise window");
		read_chk(CAUSE_REG_ADDR, 1'b1, 1'b1, 8'h00);
		$display("test supply_dip done");
		mv <= 13'h06A4;
		repeat (8) @(posedge clk);
		cmp1(run, 1'b0, "default low-voltage dip");
		mv <= 13'h09C4;
		wait_run();
		cmp1(n >= QMIN * TC && n <= QMAX * TC + SLK, 1'b1, "dip recovery window");
		read_chk(CAUSE_REG_ADDR, 1'b1, 1'b1, 8'h01);
		$display("test lvd_dip done");
		arst_n <= 1'b0;
		strap <= 1'b1;
		@(posedge clk);
		#1;
		cmp1(irst_n, 1'b0, "reset held mid-run");
		cmp8(rdata, 8'h00, "read data in reset");
		cmp1(lvd_en, 1'b1, "low-voltage start in reset");
		arst_n <= 1'b1;
		wait_run();
		cmp1(n >= QMIN * TC && n <= QMAX * TC + SLK, 1'b1, "strap start window");
		cmp1(lvd_en, 1'b0, "default low-voltage start off");
		mv <= 13'h06A4;
		repeat (8) @(posedge clk);
		cmp1(run, 1'b1, "no dip hold with start off");
		read_chk(CAUSE_REG_ADDR, 1'b1, 1'b1, 8'h00);
		$display("test strap_restart done");
		conclude();
	end
endmodule
